// [logic/swpm_defines.svh]
// Offsets, field positions, reset values and timing counts of the switch power manager.
// Assumes inclusion by bare name from the power manager package and module.
`ifndef SWPM_DEFINES_SVH
`define SWPM_DEFINES_SVH

// ==========================================================================
// Register map
`define SWPM_OFS_PMCTL0 12'h000
`define SWPM_OFS_CONFIG 12'h040
`define SWPM_OFS_RETRY 12'h044
`define SWPM_OFS_ACKTO 12'h048
`define SWPM_OFS_FENCE 12'h04c

// ==========================================================================
// Field positions
`define SWPM_PST_LSB 0
`define SWPM_PST_MSB 1
`define SWPM_KEEP_BIT 3
`define SWPM_PME_STS_BIT 15
`define SWPM_FENCE_ACK_LSB 8
`define SWPM_FENCE_SUP_BIT 16
`define SWPM_FENCE_WAKE_BIT 17

// ==========================================================================
// Encodings and reset values
`define SWPM_PST_D0 2'h0
`define SWPM_PST_D3 2'h3
`define SWPM_KEEP_RST 1'b1
`define SWPM_RETRY_RST 16'h0064
`define SWPM_ACKTO_RST 16'h0064

// ==========================================================================
// Timing
`define SWPM_CLK_NS 25
`define SWPM_TICK_NS 1000
`define SWPM_TICK_CYCLES (`SWPM_TICK_NS / `SWPM_CLK_NS)

`endif

// [logic/swpm_pkg.sv]
// Types shared by the switch power manager.
// Assumes the constants header is on the include path.
package swpm_pkg;
	`include "swpm_defines.svh"

	// ==========================================================================
	// Device power state of one bridge
	typedef enum logic [3:0] {
		SWPM_D0U = 4'h1,
		SWPM_D0A = 4'h2,
		SWPM_D3H = 4'h4,
		SWPM_D3C = 4'h8
	} swpm_pstate_t;

	// ==========================================================================
	// Turn-off fence aggregation state
	typedef enum logic [4:0] {
		SWPM_F_IDLE = 5'h01,
		SWPM_F_COLLECT = 5'h02,
		SWPM_F_ABANDON = 5'h04,
		SWPM_F_RETRAIN = 5'h08,
		SWPM_F_SENT = 5'h10
	} swpm_fence_t;

	// ==========================================================================
	// Request kinds and verdicts
	typedef enum logic [1:0] {
		SWPM_K_CFG0 = 2'h0,
		SWPM_K_MSG = 2'h1,
		SWPM_K_REQ = 2'h2,
		SWPM_K_CPL = 2'h3
	} swpm_kind_t;

	typedef enum logic [1:0] {
		SWPM_V_ACCEPT = 2'h0,
		SWPM_V_UR = 2'h1,
		SWPM_V_UC = 2'h2,
		SWPM_V_ROUTE = 2'h3
	} swpm_verdict_t;
endpackage

// [logic/swpm_power_mgr.sv]
// Power manager of a multi-port switch: bridge power states, PME retry and turn-off fence.
// Assumes an APB master on clk, one clock domain, link events as one-cycle input pulses.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "swpm_defines.svh"

// Functional notes
// - Four power states, fundamental reset gives D0U.
// - Software configuration moves D0U to D0A.
// - D3 write leaves D0A; D0 write leaves D3hot.
// - Context kept through D3hot by default.
// - Entering L2/L3 Ready resets the device.
// - Downstream bridge local; bridge 0 governs all.
// - D3hot bridge lets its link enter L1.
// - D3hot accepts type 0 config and messages.
// - D3hot other requests become unsupported.
// - TLP errors reported; other errors dropped in D3hot.
// - Own completions unexpected in D3hot; passing ones routed.
// - Downstream ports send hot-plug PME from D3hot.
// - Retransmit PME when status not cleared.
// - Pending PME at deep sleep raises wake.
// - Turn-off broadcast downstream, acks then collected.
// - All acks give upstream ack and L2/L3.
// - Upstream TLP before ack abandons; after, discarded.
// - Aborting TLP serviced, forwarded, or after retrain.
// - Abandon waits acks, retrains, then delivers.
// - Ack timeout: link to L2/L3, counted acked.
// - PME blocked after turn-off until D0U.
module swpm_power_mgr #(
	parameter int NUM_DS = 4,
	parameter int TICK_CYCLES = `SWPM_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic turnoff_rx,
	input wire logic us_tlp_rx,
	input wire logic us_tlp_to_switch,
	input wire logic us_l23_ready,
	input wire logic power_removed,
	input wire logic [NUM_DS-1:0] ds_active,
	input wire logic [NUM_DS-1:0] ds_ack_rx,
	input wire logic [NUM_DS-1:0] ds_link_l0,
	input wire logic [NUM_DS-1:0] hotplug_event,
	input wire logic tlp_valid,
	input wire logic [2:0] tlp_bridge,
	input wire logic tlp_secondary,
	input wire logic [1:0] tlp_kind,
	input wire logic tlp_to_bridge,
	input wire logic tlp_err,
	input wire logic internal_err,
	output logic [1:0] tlp_verdict,
	output logic tlp_verdict_valid,
	output logic err_msg_tx,
	output logic [NUM_DS:0] l1_allow,
	output logic [NUM_DS-1:0] pme_tx,
	output logic [NUM_DS-1:0] ds_turnoff_tx,
	output logic [NUM_DS-1:0] ds_l23_req,
	output logic [NUM_DS-1:0] ds_retrain,
	output logic us_ack_tx,
	output logic us_l23_req,
	output logic tlp_deliver,
	output logic tlp_discard,
	output logic sideband_wake_pin_out
);
	import swpm_pkg::*;

	localparam int NB = NUM_DS + 1;

	// ==========================================================================
	// Helpers
	function automatic logic timer_expired(input logic tick, input logic [15:0] cnt);
		timer_expired = tick && (cnt <= 16'h0001);
	endfunction

	function automatic logic [1:0] classify(input logic d3, input logic [1:0] kind,
		input logic secondary, input logic to_bridge);
		classify = SWPM_V_ROUTE;
		if (kind == SWPM_K_CPL)
			classify = (d3 && to_bridge) ? SWPM_V_UC : (to_bridge ? SWPM_V_ACCEPT : SWPM_V_ROUTE);
		else if (!d3)
			classify = to_bridge ? SWPM_V_ACCEPT : SWPM_V_ROUTE;
		else if (!secondary && (kind == SWPM_K_CFG0 || (kind == SWPM_K_MSG && to_bridge)))
			classify = SWPM_V_ACCEPT;
		else
			classify = SWPM_V_UR;
	endfunction

	// ==========================================================================
	// State
	swpm_pstate_t pst_reg [NB];
	swpm_pstate_t pst_next [NB];
	swpm_fence_t fence_reg, fence_next;
	logic [NB-1:0] cfg_reg, cfg_next, keep_reg, keep_next, pme_sts_reg, pme_sts_next;
	logic [15:0] retry_to_reg, retry_to_next, ackto_reg, ackto_next, tick_reg, tick_next;
	logic [15:0] retry_cnt_reg [NUM_DS];
	logic [15:0] retry_cnt_next [NUM_DS];
	logic [15:0] ack_cnt_reg [NUM_DS];
	logic [15:0] ack_cnt_next [NUM_DS];
	logic [NUM_DS-1:0] pme_wait_reg, pme_wait_next, acked_reg, acked_next;
	logic [NUM_DS-1:0] pme_tx_next, turnoff_next, l23_next, retrain_next;
	logic [NUM_DS:0] l1_next;
	logic suppress_reg, suppress_next, wake_reg, wake_next, held_reg, held_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next, us_ack_next, us_l23_next, deliver_next, discard_next;
	logic [1:0] verdict_next;
	logic verdict_valid_next, err_next;
	logic tick, wr, rd, d3_dev;
	logic [NB-1:0] d3_eff;

	assign tick = (tick_reg == 16'h0000);
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign d3_dev = (pst_reg[0] == SWPM_D3H);

	// ==========================================================================
	// Power states, register writes and the PME retry timers
	always_comb
	begin
		for (int b = 0; b < NB; b++)
		begin
			pst_next[b] = pst_reg[b];
			d3_eff[b] = (pst_reg[b] == SWPM_D3H) || d3_dev;
		end
		cfg_next = cfg_reg;
		keep_next = keep_reg;
		pme_sts_next = pme_sts_reg;
		retry_to_next = retry_to_reg;
		ackto_next = ackto_reg;
		suppress_next = suppress_reg;
		tick_next = tick ? 16'((TICK_CYCLES > 0 ? TICK_CYCLES : 1) - 1) : tick_reg - 16'h0001;
		pme_wait_next = pme_wait_reg;
		pme_tx_next = '0;
		l1_next = '0;
		for (int i = 0; i < NUM_DS; i++)
			retry_cnt_next[i] = retry_cnt_reg[i];
		if (wr && paddr == `SWPM_OFS_CONFIG)
			cfg_next = cfg_reg | pwdata[NB-1:0];
		if (wr && paddr == `SWPM_OFS_RETRY)
			retry_to_next = pwdata[15:0];
		if (wr && paddr == `SWPM_OFS_ACKTO)
			ackto_next = pwdata[15:0];
		for (int b = 0; b < NB; b++)
		begin
			if (wr && paddr == `SWPM_OFS_PMCTL0 + 12'(4 * b))
			begin
				keep_next[b] = pwdata[`SWPM_KEEP_BIT];
				if (pwdata[`SWPM_PME_STS_BIT])
					pme_sts_next[b] = 1'b0;
				if (pst_reg[b] == SWPM_D0A && pwdata[`SWPM_PST_MSB:`SWPM_PST_LSB] == `SWPM_PST_D3)
					pst_next[b] = SWPM_D3H;
				if (pst_reg[b] == SWPM_D3H && pwdata[`SWPM_PST_MSB:`SWPM_PST_LSB] == `SWPM_PST_D0)
				begin
					pst_next[b] = SWPM_D0U;
					// Without context retention software must configure the bridge again.
					if (!keep_reg[b])
						cfg_next[b] = 1'b0;
					if (b == 0)
						suppress_next = 1'b0;
				end
			end
			else if (pst_reg[b] == SWPM_D0U && cfg_reg[b])
				pst_next[b] = SWPM_D0A;
			if (pst_reg[b] == SWPM_D3H && power_removed)
				pst_next[b] = SWPM_D3C;
			l1_next[b] = d3_eff[b];
		end
		for (int i = 0; i < NUM_DS; i++)
		begin
			// A new event wins over a clear written in the same cycle.
			if (hotplug_event[i])
				pme_sts_next[i+1] = 1'b1;
			if (!pme_sts_reg[i+1])
				pme_wait_next[i] = 1'b0;
			else if (!pme_wait_reg[i] && !suppress_reg)
			begin
				pme_tx_next[i] = 1'b1;
				pme_wait_next[i] = 1'b1;
				retry_cnt_next[i] = retry_to_reg;
			end
			else if (pme_wait_reg[i] && timer_expired(tick, retry_cnt_reg[i]))
			begin
				pme_tx_next[i] = !suppress_reg;
				retry_cnt_next[i] = retry_to_reg;
			end
			else if (pme_wait_reg[i] && tick)
				retry_cnt_next[i] = retry_cnt_reg[i] - 16'h0001;
		end
		if (turnoff_rx)
			suppress_next = 1'b1;
		if (us_l23_ready)
		begin
			for (int b = 0; b < NB; b++)
				pst_next[b] = SWPM_D0U;
			cfg_next = '0;
			suppress_next = 1'b0;
			pme_wait_next = '0;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int b = 0; b < NB; b++)
				pst_reg[b] <= SWPM_D0U;
			cfg_reg <= '0;
			keep_reg <= {NB{`SWPM_KEEP_RST}};
			pme_sts_reg <= '0;
			retry_to_reg <= `SWPM_RETRY_RST;
			ackto_reg <= `SWPM_ACKTO_RST;
			suppress_reg <= 1'b0;
			tick_reg <= 16'h0000;
			pme_wait_reg <= '0;
			pme_tx <= '0;
			l1_allow <= '0;
			for (int i = 0; i < NUM_DS; i++)
				retry_cnt_reg[i] <= 16'h0000;
		end
		else
		begin
			pst_reg <= pst_next;
			cfg_reg <= cfg_next;
			keep_reg <= keep_next;
			pme_sts_reg <= pme_sts_next;
			retry_to_reg <= retry_to_next;
			ackto_reg <= ackto_next;
			suppress_reg <= suppress_next;
			tick_reg <= tick_next;
			pme_wait_reg <= pme_wait_next;
			pme_tx <= pme_tx_next;
			l1_allow <= l1_next;
			retry_cnt_reg <= retry_cnt_next;
		end
	end

	// ==========================================================================
	// Turn-off fence aggregation
	always_comb
	begin
		fence_next = fence_reg;
		acked_next = acked_reg;
		held_next = held_reg;
		wake_next = wake_reg && (pme_sts_reg != '0);
		turnoff_next = '0;
		l23_next = ds_l23_req;
		retrain_next = ds_retrain;
		us_ack_next = 1'b0;
		us_l23_next = us_l23_req;
		deliver_next = 1'b0;
		discard_next = 1'b0;
		for (int i = 0; i < NUM_DS; i++)
		begin
			ack_cnt_next[i] = ack_cnt_reg[i];
			if (fence_reg == SWPM_F_COLLECT || fence_reg == SWPM_F_ABANDON)
			begin
				if (!acked_reg[i] && (ds_ack_rx[i] || timer_expired(tick, ack_cnt_reg[i])))
				begin
					acked_next[i] = 1'b1;
					l23_next[i] = 1'b1;
				end
				else if (!acked_reg[i] && tick)
					ack_cnt_next[i] = ack_cnt_reg[i] - 16'h0001;
			end
		end
		unique case (fence_reg)
			SWPM_F_IDLE:
				if (turnoff_rx)
				begin
					fence_next = SWPM_F_COLLECT;
					turnoff_next = ds_active;
					acked_next = ~ds_active;
					for (int i = 0; i < NUM_DS; i++)
						ack_cnt_next[i] = ackto_reg;
				end
			SWPM_F_COLLECT:
				if (us_tlp_rx)
				begin
					fence_next = SWPM_F_ABANDON;
					// Switch-bound traffic is served at once; the rest waits for retrain.
					deliver_next = us_tlp_to_switch;
					held_next = !us_tlp_to_switch;
				end
				else if (&acked_reg)
				begin
					fence_next = SWPM_F_SENT;
					us_ack_next = 1'b1;
					us_l23_next = 1'b1;
					wake_next = (pme_sts_reg != '0);
				end
			SWPM_F_ABANDON:
			begin
				if (us_tlp_rx)
					discard_next = 1'b1;
				if (&acked_reg)
				begin
					fence_next = SWPM_F_RETRAIN;
					retrain_next = ds_active & ~ds_link_l0;
					l23_next = '0;
				end
			end
			SWPM_F_RETRAIN:
				if (&(ds_link_l0 | ~ds_active))
				begin
					fence_next = SWPM_F_IDLE;
					retrain_next = '0;
					deliver_next = held_reg;
					held_next = 1'b0;
				end
			SWPM_F_SENT:
				discard_next = us_tlp_rx;
		endcase
		if (us_l23_ready)
		begin
			fence_next = SWPM_F_IDLE;
			acked_next = '0;
			l23_next = '0;
			retrain_next = '0;
			us_l23_next = 1'b0;
			held_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fence_reg <= SWPM_F_IDLE;
			acked_reg <= '0;
			held_reg <= 1'b0;
			wake_reg <= 1'b0;
			ds_turnoff_tx <= '0;
			ds_l23_req <= '0;
			ds_retrain <= '0;
			us_ack_tx <= 1'b0;
			us_l23_req <= 1'b0;
			tlp_deliver <= 1'b0;
			tlp_discard <= 1'b0;
			sideband_wake_pin_out <= 1'b0;
			for (int i = 0; i < NUM_DS; i++)
				ack_cnt_reg[i] <= 16'h0000;
		end
		else
		begin
			fence_reg <= fence_next;
			acked_reg <= acked_next;
			held_reg <= held_next;
			wake_reg <= wake_next;
			ds_turnoff_tx <= turnoff_next;
			ds_l23_req <= l23_next;
			ds_retrain <= retrain_next;
			us_ack_tx <= us_ack_next;
			us_l23_req <= us_l23_next;
			tlp_deliver <= deliver_next;
			tlp_discard <= discard_next;
			sideband_wake_pin_out <= wake_next;
			ack_cnt_reg <= ack_cnt_next;
		end
	end

	// ==========================================================================
	// Request classification and error messages
	always_comb
	begin
		verdict_next = SWPM_V_ROUTE;
		verdict_valid_next = 1'b0;
		err_next = 1'b0;
		if (tlp_bridge < 3'(NB))
		begin
			verdict_next = classify(d3_eff[tlp_bridge], tlp_kind, tlp_secondary, tlp_to_bridge);
			verdict_valid_next = tlp_valid;
			// Errors from a received TLP always report; others are dropped in D3hot.
			err_next = (tlp_valid && tlp_err) || (internal_err && !d3_eff[tlp_bridge]);
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tlp_verdict <= 2'h0;
			tlp_verdict_valid <= 1'b0;
			err_msg_tx <= 1'b0;
		end
		else
		begin
			tlp_verdict <= verdict_next;
			tlp_verdict_valid <= verdict_valid_next;
			err_msg_tx <= err_next;
		end
	end

	// ==========================================================================
	// APB slave: one wait-free access cycle after setup
	always_comb
	begin
		pready_next = psel && !penable;
		pslverr_next = 1'b0;
		prdata_next = prdata;
		if (psel && !penable)
		begin
			prdata_next = 32'h0000_0000;
			pslverr_next = 1'b1;
			for (int b = 0; b < NB; b++)
				if (paddr == `SWPM_OFS_PMCTL0 + 12'(4 * b))
				begin
					pslverr_next = 1'b0;
					prdata_next[`SWPM_PST_MSB:`SWPM_PST_LSB] =
						(pst_reg[b] == SWPM_D3H || pst_reg[b] == SWPM_D3C) ? `SWPM_PST_D3 : `SWPM_PST_D0;
					prdata_next[`SWPM_KEEP_BIT] = keep_reg[b];
					prdata_next[`SWPM_PME_STS_BIT] = pme_sts_reg[b];
				end
			if (paddr == `SWPM_OFS_CONFIG)
			begin
				pslverr_next = 1'b0;
				for (int b = 0; b < NB; b++)
					prdata_next[b] = (pst_reg[b] == SWPM_D0A);
			end
			if (paddr == `SWPM_OFS_RETRY || paddr == `SWPM_OFS_ACKTO)
			begin
				pslverr_next = 1'b0;
				prdata_next[15:0] = (paddr == `SWPM_OFS_RETRY) ? retry_to_reg : ackto_reg;
			end
			if (paddr == `SWPM_OFS_FENCE)
			begin
				pslverr_next = 1'b0;
				prdata_next[4:0] = fence_reg;
				prdata_next[`SWPM_FENCE_ACK_LSB +: NUM_DS] = acked_reg;
				prdata_next[`SWPM_FENCE_SUP_BIT] = suppress_reg;
				prdata_next[`SWPM_FENCE_WAKE_BIT] = wake_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end
endmodule // swpm_power_mgr

// [testbench/swpm_link_model.sv]
// Behavioural model of the downstream link partners of the switch power manager.
// Assumes one clock; each port answers a turn-off after its own delay unless muted.
`timescale 1ns/1ps
module swpm_link_model #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [N-1:0] ds_turnoff_tx,
	input wire logic [N-1:0] ds_l23_req,
	input wire logic [N-1:0] ds_retrain,
	input wire logic [N-1:0] mute,
	output logic [N-1:0] ds_ack_rx,
	output logic [N-1:0] ds_link_l0
);
	// ==========
	// Per-port answer delay and link state
	int cnt [N];

	// Delays differ per port so that acks arrive both promptly and late.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ds_ack_rx <= '0;
			ds_link_l0 <= '1;
			for (int i = 0; i < N; i++)
				cnt[i] <= 0;
		end
		else
			for (int i = 0; i < N; i++)
			begin
				ds_ack_rx[i] <= cnt[i] == 1;
				if (ds_turnoff_tx[i] && !mute[i])
					cnt[i] <= 2 + 3 * i;
				else if (cnt[i] > 0)
					cnt[i] <= cnt[i] - 1;
				if (ds_retrain[i])
					ds_link_l0[i] <= 1'b1;
				else if (ds_ack_rx[i] || ds_l23_req[i])
					ds_link_l0[i] <= 1'b0;
			end
	end
endmodule // swpm_link_model

// [testbench/swpm_props.sv]
// Concurrent checks on the ports of the switch power manager.
// Assumes one clock domain and binding to every swpm_power_mgr instance.
`timescale 1ns/1ps
module swpm_props #(
	parameter int NUM_DS = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic turnoff_rx,
	input wire logic us_tlp_rx,
	input wire logic us_l23_ready,
	input wire logic tlp_valid,
	input wire logic [2:0] tlp_bridge,
	input wire logic tlp_secondary,
	input wire logic [1:0] tlp_kind,
	input wire logic tlp_to_bridge,
	input wire logic tlp_err,
	input wire logic internal_err,
	input wire logic [1:0] tlp_verdict,
	input wire logic tlp_verdict_valid,
	input wire logic err_msg_tx,
	input wire logic [NUM_DS:0] l1_allow,
	input wire logic [NUM_DS-1:0] pme_tx,
	input wire logic us_ack_tx,
	input wire logic us_l23_req,
	input wire logic tlp_discard
);
	// ==========
	// Helper state
	logic sup_reg;
	logic sup_next;
	logic sent_reg;
	logic sent_next;

	// Any write to bridge 0 ends the window, so a write that clears suppression never false-fires.
	always_comb
	begin
		sup_next = turnoff_rx | (sup_reg & ~us_l23_ready & ~(psel & penable & pwrite & paddr == 12'h000));
		sent_next = us_ack_tx | (sent_reg & ~us_l23_ready);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sup_reg <= 1'b0;
			sent_reg <= 1'b0;
		end
		else
		begin
			sup_reg <= sup_next;
			sent_reg <= sent_next;
		end
	end

	// ==========
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_pready;
		psel && !penable |=> pready;
	endproperty
	a_pready: assert property (p_pready) else $error("pready missing after setup");
	property p_unmapped;
		psel && !penable && paddr >= 12'h050 |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_verdict_valid;
		tlp_valid && int'(tlp_bridge) <= NUM_DS |=> tlp_verdict_valid;
	endproperty
	a_verdict_valid: assert property (p_verdict_valid) else $error("verdict missing");
	property p_ur;
		tlp_valid && tlp_secondary && tlp_kind == 2'h2 && tlp_bridge == 3'h1 && l1_allow[1]
			|=> tlp_verdict == 2'h1;
	endproperty
	a_ur: assert property (p_ur) else $error("secondary request not unsupported");
	property p_cpl;
		tlp_valid && tlp_kind == 2'h3 && !tlp_to_bridge && int'(tlp_bridge) <= NUM_DS
			|=> tlp_verdict == 2'h3;
	endproperty
	a_cpl: assert property (p_cpl) else $error("passing completion not routed");
	property p_err_tlp;
		tlp_valid && tlp_err && int'(tlp_bridge) <= NUM_DS |=> err_msg_tx;
	endproperty
	a_err_tlp: assert property (p_err_tlp) else $error("packet error not reported");
	property p_l1;
		l1_allow[0] |-> &l1_allow;
	endproperty
	a_l1: assert property (p_l1) else $error("upstream sleep not applied to all");
	property p_ack_l23;
		us_ack_tx |-> ##[0:1] us_l23_req;
	endproperty
	a_ack_l23: assert property (p_ack_l23) else $error("upstream link not sent to sleep");
	property p_suppress;
		sup_reg && $past(sup_reg) |-> pme_tx == '0;
	endproperty
	a_suppress: assert property (p_suppress) else $error("PME sent after turn-off");
	property p_discard;
		sent_reg && us_tlp_rx |=> tlp_discard;
	endproperty
	a_discard: assert property (p_discard) else $error("late packet not discarded");
endmodule // swpm_props

bind swpm_power_mgr swpm_props #(.NUM_DS(NUM_DS)) u_props (.clk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .turnoff_rx, .us_tlp_rx, .us_l23_ready,
	.tlp_valid, .tlp_bridge, .tlp_secondary, .tlp_kind, .tlp_to_bridge, .tlp_err,
	.internal_err, .tlp_verdict, .tlp_verdict_valid, .err_msg_tx, .l1_allow, .pme_tx,
	.us_ack_tx, .us_l23_req, .tlp_discard);

// [testbench/swpm_tb.sv]
// Self-checking bench for the switch power manager with a behavioural reference.
// Assumes the package, the design, the link model and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
	import swpm_pkg::*;
	localparam int N = 4;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, perr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, turnoff_rx, us_tlp_rx, us_tlp_to_switch = 0;
	logic us_l23_ready, power_removed = 0, tlp_valid, tlp_secondary = 0;
	logic tlp_to_bridge = 0, tlp_err = 0, internal_err, us_ack_tx, us_l23_req;
	logic [2:0] tlp_bridge = '0;
	logic [1:0] tlp_kind = '0, tlp_verdict;
	logic [N-1:0] ds_active = '1, ds_ack_rx, ds_link_l0, hotplug_event, mute = '0;
	logic [N-1:0] pme_tx, ds_turnoff_tx, ds_l23_req, ds_retrain;
	logic [N:0] l1_allow;
	logic tlp_verdict_valid, err_msg_tx, tlp_deliver, tlp_discard, wake, saw_rt = 0, saw_ack = 0;
	int bad_count = 0, checks_done = 0, cyc = 0, pq[$];
	// Strobe bits: packet, internal error, hot-plug 0, turn-off, upstream packet, link sleep.
	logic [5:0] strb = '0;

	assign {us_l23_ready, us_tlp_rx, turnoff_rx, internal_err, tlp_valid} = {strb[5:3], strb[1:0]};
	assign hotplug_event = {{(N-1){1'b0}}, strb[2]};

	always #12.5 clk = ~clk;

	// Tick of two clocks keeps the timer scenarios short.
	swpm_power_mgr #(.NUM_DS(N), .TICK_CYCLES(2)) dut (.clk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .turnoff_rx, .us_tlp_rx, .us_tlp_to_switch,
		.us_l23_ready, .power_removed, .ds_active, .ds_ack_rx, .ds_link_l0, .hotplug_event,
		.tlp_valid, .tlp_bridge, .tlp_secondary, .tlp_kind, .tlp_to_bridge, .tlp_err,
		.internal_err, .tlp_verdict, .tlp_verdict_valid, .err_msg_tx, .l1_allow, .pme_tx,
		.ds_turnoff_tx, .ds_l23_req, .ds_retrain, .us_ack_tx, .us_l23_req, .tlp_deliver,
		.tlp_discard, .sideband_wake_pin_out(wake));
	swpm_link_model #(.N(N)) peer (.clk, .reset_n, .ds_turnoff_tx, .ds_l23_req, .ds_retrain,
		.mute, .ds_ack_rx, .ds_link_l0);

	// ==========
	// Monitor and reference
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (pme_tx[0] === 1'b1)
			pq.push_back(cyc);
		if (ds_retrain !== '0)
			saw_rt <= 1;
		if (us_ack_tx === 1'b1)
			saw_ack <= 1;
	end

	function automatic logic [1:0] vexp(input logic d3, input logic s, input logic [1:0] k,
		input logic t);
		if (k == SWPM_K_CPL)
			return (t && d3) ? SWPM_V_UC : (t ? SWPM_V_ACCEPT : SWPM_V_ROUTE);
		if (!d3)
			return t ? SWPM_V_ACCEPT : SWPM_V_ROUTE;
		return (!s && (k == SWPM_K_CFG0 || (k == SWPM_K_MSG && t))) ? SWPM_V_ACCEPT : SWPM_V_UR;
	endfunction

	// ==========
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		chk("pready", 1, {31'h0, pready});
		psel <= 0;
		penable <= 0;
		repeat (3) @(posedge clk);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(nm, e, rd);
	endtask

	task automatic pulse(input logic [5:0] m);
		strb <= m;
		@(posedge clk);
		strb <= '0;
		@(posedge clk);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		wrap_up();
	end

	// ==========
	// Main sequence
	initial
	begin
		void'($urandom(80954));
		repeat (4) @(posedge clk);
		reset_n <= 1;
		for (int b = 0; b <= N; b++)
			rdc("pm ctl", 12'(4 * b), 32'h8);
		rdc("config", 12'h040, 0);
		rdc("retry", 12'h044, 32'h64);
		rdc("ackto", 12'h048, 32'h64);
		rdc("fence", 12'h04c, 1);
		apb(1, 12'h100, 32'hf);
		chk("slverr", 1, {31'h0, perr});
		apb(1, 12'h040, 32'h1f);
		rdc("config", 12'h040, 32'h1f);
		apb(1, 12'h004, 32'hb);
		rdc("config", 12'h040, 32'h1d);
		chk("l1 local", 5'h02, {27'h0, l1_allow});
		repeat (40)
		begin
			tlp_bridge <= 3'($urandom_range(1));
			tlp_secondary <= 1'($urandom);
			tlp_kind <= 2'($urandom);
			tlp_to_bridge <= 1'($urandom);
			tlp_err <= 1'($urandom);
			pulse(6'h01);
			chk("verdict", {1'b1, vexp(tlp_bridge == 1, tlp_secondary, tlp_kind, tlp_to_bridge)},
				{tlp_verdict_valid, tlp_verdict});
			chk("err msg", {31'h0, tlp_err}, {31'h0, err_msg_tx});
		end
		for (int b = 0; b < 2; b++)
		begin
			tlp_bridge <= 3'(b);
			pulse(6'h02);
			chk("int err", b == 0, {31'h0, err_msg_tx});
		end
		apb(1, 12'h000, 32'hb);
		chk("l1 all", 5'h1f, {27'h0, l1_allow});
		apb(1, 12'h000, 32'h8);
		apb(1, 12'h044, 32'h3);
		pq.delete();
		pulse(6'h04);
		repeat (40) @(posedge clk);
		chk("pme count", 1, pq.size() >= 3);
		if (pq.size() >= 3)
			chk("pme gap", 6, pq[2] - pq[1]);
		rdc("pm ctl 1", 12'h004, 32'h800b);
		apb(1, 12'h004, 32'h800b);
		pq.delete();
		repeat (30) @(posedge clk);
		chk("pme stop", 0, pq.size());
		apb(1, 12'h004, 32'h8);
		rdc("config", 12'h040, 32'h1f);
		apb(1, 12'h008, 32'h3);
		apb(1, 12'h008, 32'h0);
		rdc("config", 12'h040, 32'h1b);
		apb(1, 12'h048, 32'h4);
		pulse(6'h04);
		ds_active <= 4'b0111;
		mute <= 4'b0100;
		pulse(6'h08);
		chk("turnoff", 4'b0111, ds_turnoff_tx);
		repeat (100)
		begin
			@(posedge clk);
			if (us_ack_tx === 1'b1)
				break;
		end
		chk("us ack", 1, {31'h0, us_ack_tx});
		chk("l23 req", 4'b0111, ds_l23_req);
		@(posedge clk);
		chk("us l23", 3, {30'h0, us_l23_req, wake});
		rdc("fence", 12'h04c, 32'h30f10);
		us_tlp_to_switch <= 1;
		pulse(6'h10);
		chk("discard", 1, {31'h0, tlp_discard});
		pulse(6'h20);
		rdc("config", 12'h040, 0);
		ds_active <= 4'b0011;
		mute <= '0;
		saw_rt = 0;
		saw_ack = 0;
		pulse(6'h08);
		us_tlp_to_switch <= 0;
		pulse(6'h10);
		repeat (200)
		begin
			@(posedge clk);
			if (tlp_deliver === 1'b1)
				break;
		end
		chk("abandon", 3'b110, {tlp_deliver, saw_rt, saw_ack});
		apb(0, 12'h04c, 0);
		chk("fence idle", 1, rd & 32'h1f);
		// Power loss takes a sleeping bridge to D3cold, where a D0 write no longer wakes it.
		apb(1, 12'h040, 32'h2);
		apb(1, 12'h004, 32'hb);
		power_removed <= 1;
		@(posedge clk);
		power_removed <= 0;
		apb(1, 12'h004, 32'h8);
		rdc("pm ctl 1", 12'h004, 32'h800b);
		wrap_up();
	end
endmodule // testbench
